// ### rtl/spc_pkg.sv
// shared constants for the serial configuration port register bank
`default_nettype none

package spc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register offsets (13-bit serial address space)
  localparam logic [12:0] ADDR_PORT_CFG   = 13'h000;
  localparam logic [12:0] ADDR_VARIANT_ID = 13'h003;
  localparam logic [12:0] ADDR_RB_SEL     = 13'h004;
  localparam logic [12:0] ADDR_PD_SYNC    = 13'h230;
  localparam logic [12:0] ADDR_RSVD_SYS   = 13'h231;
  localparam logic [12:0] ADDR_APPLY      = 13'h232;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FOUR_WIRE_BIT  = 0;
  localparam int LSB_FIRST_BIT  = 1;
  localparam int SOFT_RST_BIT   = 2;
  localparam int LONG_INSTR_BIT = 3;
  localparam int RB_SEL_BIT     = 0;
  localparam int APPLY_BIT      = 0;
  localparam int INSTR_RW_BIT   = 15;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] RB_SEL_RST   = 8'h00;
  localparam logic [7:0] PD_SYNC_RST  = 8'h00;
  localparam logic [7:0] RSVD_RST     = 8'h00;
  localparam logic [7:0] APPLY_RST    = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // framing counts
  localparam logic [3:0] INSTR_LAST  = 4'hf;
  localparam logic [3:0] BYTE_LAST   = 4'h7;
  localparam logic [1:0] XFER_STREAM = 2'h3;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10,
    ST_DONE  = 2'b11
  } spc_state_t;

endpackage : spc_pkg

`default_nettype wire

// ### rtl/spc_pulse_rx.sv
// toggle receiver: synchronises a toggle and marks each change
`timescale 1ns/10ps
`default_nettype none

module spc_pulse_rx (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tgl_in,
  output logic      level,
  output logic      pulse
);

  logic meta;
  logic sync;

  always_ff @(posedge clk) begin
    meta <= tgl_in;
    sync <= meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      pulse <= 1'b0;
    end else begin
      level <= sync;
      pulse <= sync ^ level;
    end
  end

endmodule : spc_pulse_rx

`default_nettype wire

// ### rtl/spc_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none

module spc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end

endmodule : spc_sync

`default_nettype wire

// ### rtl/spc_top.sv
// serial configuration port with buffered register bank
//
// Summary of operation
// RULE_01: host mirrors port config low nibble upward
// RULE_02: only 16-bit instructions are accepted
// RULE_03: soft reset restores defaults, never self-clears
// RULE_04: host clears soft reset to finish it
// RULE_05: lsb-first mode shifts lsb first, address increments
// RULE_06: msb-first default, address decrements
// RULE_07: three-wire default: dedicated output stays undriven
// RULE_08: four-wire: reads on dedicated output pin
// RULE_09: fixed read-only variant identifier register
// RULE_10: bank select zero reads buffered registers
// RULE_11: bank select one reads active registers
// RULE_12: apply bit clears itself after being written
// RULE_13: apply copies buffered values into active set
`timescale 1ns/10ps
`default_nettype none

module spc_top #(
  // arbitrary neutral identifier value
  parameter logic [7:0] VARIANT_ID = 8'h5a
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  output logic            dedicated_read_output_pin,
  output logic            dedicated_read_output_pin_oe,
  output logic      [7:0] active_powerdown_sync,
  output logic            soft_reset_active,
  output logic            apply_pulse
);

  import spc_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // link domain declarations
  logic             link_rst;
  spc_state_t       state;
  logic [3:0]       bit_cnt;
  logic [15:0]      ins;
  logic [15:0]      next_ins;
  logic [7:0]       dat;
  logic [7:0]       next_dat;
  logic [12:0]      addr;
  logic [12:0]      next_addr;
  logic [1:0]       left;
  logic [7:0]       rd_byte;
  logic [7:0]       port_cfg_link;
  logic             lsb_first;
  logic             four_wire_select;
  logic [12:0]      wr_addr;
  logic [7:0]       wr_data;
  logic             wr_tgl;
  logic [15:0]      snap_link;
  logic             snap_seen;
  logic             snap_new;
  logic             rd_bit;
  logic [2:0]       rd_idx;

  //////////////////////////////////////////////////////////////////////////
  // system domain declarations
  logic             wr_pulse;
  logic [7:0]       port_cfg;
  logic             soft_rst;
  logic [7:0]       rb_sel;
  logic [7:0]       pd_buf;
  logic [15:0]      snap_bus;
  logic [15:0]      snap_view;
  logic             snap_tgl;
  logic             snap_ack;

  //////////////////////////////////////////////////////////////////////////
  // crossings
  spc_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk  (sclk),
    .din  (rst),
    .dout (link_rst)
  );

  spc_pulse_rx u_snap_rx (
    .clk    (sclk),
    .rst    (link_rst),
    .tgl_in (snap_tgl),
    .level  (snap_seen),
    .pulse  (snap_new)
  );

  spc_sync #(
    .WIDTH (1)
  ) u_ack_sync (
    .clk  (sys_clk),
    .din  (snap_seen),
    .dout (snap_ack)
  );

  spc_pulse_rx u_wr_rx (
    .clk    (sys_clk),
    .rst    (rst),
    .tgl_in (wr_tgl),
    .level  (),
    .pulse  (wr_pulse)
  );

  //////////////////////////////////////////////////////////////////////////
  // link side: mode bits and readback lookup
  // decode from the low nibble; the host keeps the high one mirrored
  assign lsb_first        = port_cfg_link[LSB_FIRST_BIT];  // see RULE_01
  assign four_wire_select = port_cfg_link[FOUR_WIRE_BIT];

  function automatic logic [7:0] rd_lookup(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_PORT_CFG:   v = port_cfg_link;
      ADDR_VARIANT_ID: v = VARIANT_ID;  // see RULE_09
      ADDR_RB_SEL:     v = snap_link[15:8];
      ADDR_PD_SYNC:    v = snap_link[7:0];
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : rd_lookup

  always_comb begin
    if (lsb_first) begin
      next_ins  = {sdio_in, ins[15:1]};  // see RULE_05
      next_dat  = {sdio_in, dat[7:1]};
      next_addr = 13'(addr + 13'h001);
    end else begin
      next_ins  = {ins[14:0], sdio_in};  // see RULE_06
      next_dat  = {dat[6:0], sdio_in};
      next_addr = 13'(addr - 13'h001);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link side: frame sequencer, cleared whenever the chip select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      state   <= ST_INSTR;
      bit_cnt <= 4'h0;
      ins     <= 16'h0000;
      dat     <= 8'h00;
      addr    <= 13'h0000;
      left    <= 2'h0;
      rd_byte <= 8'h00;
    end else begin
      case (state)
        ST_INSTR: begin
          ins     <= next_ins;
          bit_cnt <= 4'(bit_cnt + 4'h1);
          // the short form is never decoded
          if (bit_cnt == INSTR_LAST) begin  // see RULE_02
            bit_cnt <= 4'h0;
            addr    <= next_ins[12:0];
            left    <= next_ins[14:13];
            rd_byte <= rd_lookup(next_ins[12:0]);
            if (next_ins[INSTR_RW_BIT]) begin
              state <= ST_READ;
            end else begin
              state <= ST_WRITE;
            end
          end
        end
        ST_WRITE, ST_READ: begin
          dat     <= next_dat;
          bit_cnt <= 4'(bit_cnt + 4'h1);
          if (bit_cnt == BYTE_LAST) begin
            bit_cnt <= 4'h0;
            addr    <= next_addr;  // see RULE_05
            rd_byte <= rd_lookup(next_addr);
            if (left != XFER_STREAM) begin
              if (left == 2'h0) begin
                state <= ST_DONE;
              end else begin
                left <= 2'(left - 2'h1);
              end
            end
          end
        end
        ST_DONE: begin
          bit_cnt <= 4'h0;
        end
        default: begin
          state <= ST_DONE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link side: completed write bytes, held until the next write byte ends
  // the held bus gives the system side 8 link edges to sample it
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      wr_addr       <= 13'h0000;
      wr_data       <= 8'h00;
      wr_tgl        <= 1'b0;
      port_cfg_link <= PORT_CFG_RST;
    end else if (!cs_n && state == ST_WRITE && bit_cnt == BYTE_LAST) begin
      wr_addr <= addr;
      wr_data <= next_dat;
      wr_tgl  <= ~wr_tgl;
      // local copy so the mode holds from the next frame on
      if (addr == ADDR_PORT_CFG) begin
        port_cfg_link <= next_dat;
      end
    end
  end

  // readback copy of the system bank, taken on each handshake
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      snap_link <= {RB_SEL_RST, PD_SYNC_RST};
    end else if (snap_new) begin
      snap_link <= snap_bus;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link side: read data launched on the falling edge
  always_comb begin
    if (lsb_first) begin
      rd_idx = bit_cnt[2:0];
    end else begin
      rd_idx = 3'(3'h7 - bit_cnt[2:0]);
    end
    rd_bit = rd_byte[rd_idx];
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdio_out                     <= 1'b0;
      sdio_oe                      <= 1'b0;
      dedicated_read_output_pin    <= 1'b0;
      dedicated_read_output_pin_oe <= 1'b0;
    end else begin
      sdio_out                     <= rd_bit;
      dedicated_read_output_pin    <= rd_bit;
      sdio_oe                      <= (state == ST_READ)
                                      && !four_wire_select;  // see RULE_07
      dedicated_read_output_pin_oe <= (state == ST_READ)
                                      && four_wire_select;   // see RULE_08
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system side: port configuration, never cleared by soft reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_cfg <= PORT_CFG_RST;
    end else if (wr_pulse && wr_addr == ADDR_PORT_CFG) begin
      port_cfg <= wr_data;  // see RULE_04
    end
  end

  // stays set until the host writes it back to zero
  assign soft_rst          = port_cfg[SOFT_RST_BIT];  // see RULE_03
  assign soft_reset_active = port_cfg[SOFT_RST_BIT];

  //////////////////////////////////////////////////////////////////////////
  // system side: buffered and active bank
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin  // see RULE_03
      rb_sel                <= RB_SEL_RST;
      pd_buf                <= PD_SYNC_RST;
      active_powerdown_sync <= PD_SYNC_RST;
      apply_pulse           <= APPLY_RST[APPLY_BIT];
    end else begin
      apply_pulse <= 1'b0;  // see RULE_12
      if (wr_pulse && wr_addr == ADDR_RB_SEL) begin
        rb_sel <= wr_data;
      end
      // buffered writes do nothing until applied
      if (wr_pulse && wr_addr == ADDR_PD_SYNC) begin
        pd_buf <= wr_data;  // see RULE_13
      end
      if (wr_pulse && wr_addr == ADDR_APPLY) begin
        apply_pulse <= wr_data[APPLY_BIT];  // see RULE_12
      end
      if (apply_pulse) begin
        active_powerdown_sync <= pd_buf;  // see RULE_13
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system side: readback view handed to the link by handshake
  always_comb begin
    snap_view[15:8] = rb_sel;
    if (rb_sel[RB_SEL_BIT]) begin
      snap_view[7:0] = active_powerdown_sync;  // see RULE_11
    end else begin
      snap_view[7:0] = pd_buf;  // see RULE_10
    end
  end

  // a new view goes out only once the last one was acknowledged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_bus <= {RB_SEL_RST, PD_SYNC_RST};
      snap_tgl <= 1'b0;
    end else if (snap_ack == snap_tgl && snap_view != snap_bus) begin
      snap_bus <= snap_view;
      snap_tgl <= ~snap_tgl;
    end
  end

endmodule : spc_top

`default_nettype wire

// ### verif/spc_host_model.sv
// host controller model that clocks the serial link
`timescale 1ns/10ps
`default_nettype none

module spc_host_model (
  output logic       sclk,
  output logic       cs_n,
  output logic       host_data,
  input  wire logic  sdio_out,
  input  wire logic  sdio_oe,
  input  wire logic  pin_data,
  input  wire logic  pin_oe,
  output logic [7:0] rx_byte,
  output int         rx_cnt
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_data = 1'b0;
  end
  ////////////////////////////////////////
  // link clock stands still outside frames and idle calls
  task automatic idle(input int n);
    repeat (n) begin
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask : idle

  task automatic frame(input logic rd, input logic [12:0] a, input int n,
                       input logic [7:0] wd, input logic lsb, input logic fw);
    logic [15:0] ins;
    int          k;
    ins = {rd, 2'(n - 1), a};
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      host_data = lsb ? ins[i] : ins[15 - i];
      idle(1);
    end
    for (int i = 0; i < 8 * n; i++) begin
      k = lsb ? i % 8 : 7 - i % 8;
      // released line toggles so a stale bit never reads as good
      host_data = rd ? ~host_data : wd[k];
      #3 sclk = 1'b1;
      rx_byte[k] = fw ? (pin_oe ? pin_data : ~host_data)
                      : (sdio_oe ? sdio_out : host_data);
      #3 sclk = 1'b0;
      if (rd && i % 8 == 7) rx_cnt++;
    end
    #3 cs_n = 1'b1;
    #60;
  endtask : frame
endmodule : spc_host_model

`default_nettype wire

// ### verif/spc_top_monitor.sv
// assertions on the serial configuration port bank
`timescale 1ns/10ps
`default_nettype none

module spc_top_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       sdio_oe,
  input wire logic       dedicated_read_output_pin_oe,
  input wire logic [7:0] active_powerdown_sync,
  input wire logic       soft_reset_active,
  input wire logic       apply_pulse
);
  wire logic       ro_oe;
  wire logic [7:0] act;
  assign ro_oe = dedicated_read_output_pin_oe;
  assign act = active_powerdown_sync;
  ////////////////////////////////////////
  a_one_driver:
    assert property (@(posedge sys_clk) disable iff (rst) !(sdio_oe && ro_oe))
    else $error("both read pins driven");
  a_idle_quiet:
    assert property (@(posedge sys_clk) disable iff (rst)
      cs_n && $past(cs_n) |-> !sdio_oe && !ro_oe)
    else $error("pin driven while idle");
  a_apply_single:
    assert property (@(posedge sys_clk) disable iff (rst)
      apply_pulse |=> !apply_pulse) else $error("apply strobe stuck");
  a_active_cause:
    assert property (@(posedge sys_clk) disable iff (rst)
      $changed(act) |-> $past(apply_pulse) || $past(rst)
        || $past(soft_reset_active) || soft_reset_active)
    else $error("active set changed without apply");
  a_soft_clears:
    assert property (@(posedge sys_clk) disable iff (rst)
      soft_reset_active [*3] |-> act == 8'h00) else $error("soft reset kept");
  a_soft_no_apply:
    assert property (@(posedge sys_clk) disable iff (rst)
      soft_reset_active [*3] |-> !apply_pulse) else $error("apply in reset");
  a_reset_values:
    assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> act == 8'h00 && !apply_pulse && !soft_reset_active)
    else $error("bad values after reset");
  a_sdio_byte:
    assert property (@(negedge sclk) disable iff (rst || cs_n)
      $rose(sdio_oe) |-> sdio_oe [*8]) else $error("short read on data pin");
  a_pin_byte:
    assert property (@(negedge sclk) disable iff (rst || cs_n)
      $rose(ro_oe) |-> ro_oe [*8]) else $error("short read on output pin");
  c_apply: cover property (@(posedge sys_clk) apply_pulse);
  c_pin_read: cover property (@(negedge sclk) $rose(ro_oe));
  c_soft: cover property (@(posedge sys_clk) soft_reset_active);
endmodule : spc_top_monitor

bind spc_top spc_top_monitor mon_u (
  .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_oe(sdio_oe),
  .dedicated_read_output_pin_oe(dedicated_read_output_pin_oe),
  .active_powerdown_sync(active_powerdown_sync),
  .soft_reset_active(soft_reset_active), .apply_pulse(apply_pulse));

`default_nettype wire

// ### verif/tb_spc_top.sv
// self-checking bench for the serial configuration port bank
`timescale 1ns/10ps
`default_nettype none

module tb_spc_top;
  import spc_pkg::*;
  localparam logic [7:0] VID = 8'hc5; // arbitrary identifier value
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        sclk, cs_n, hd, sdio_out, sdio_oe, pin, pin_oe, srst, apl;
  logic [7:0]  act, rx_byte, v;
  logic [7:0]  rdq[$], apq[$];
  int          rx_cnt, num_errors = 0, check_count = 0;
  logic [31:0] seed = 32'h9c78a681;
  logic        lsb = 1'b0, fw = 1'b0;
  logic [12:0] ra[6] = '{13'h000, 13'h003, 13'h004, 13'h230, 13'h231, 13'h232};
  logic [7:0]  re[6] = '{PORT_CFG_RST, VID, RB_SEL_RST, PD_SYNC_RST,
                         RSVD_RST, APPLY_RST};

  always #5 sys_clk = ~sys_clk;

  spc_top #(.VARIANT_ID(VID)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_oe ? sdio_out : hd), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .dedicated_read_output_pin(pin), .dedicated_read_output_pin_oe(pin_oe),
    .active_powerdown_sync(act), .soft_reset_active(srst), .apply_pulse(apl));

  spc_host_model host_u (
    .sclk(sclk), .cs_n(cs_n), .host_data(hd), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .pin_data(pin), .pin_oe(pin_oe), .rx_byte(rx_byte),
    .rx_cnt(rx_cnt));
  ////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host_u.frame(1'b0, a, 1, d, lsb, fw);
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [7:0] e0,
                    input int n = 1, input logic [7:0] e1 = 8'h00);
    rdq.push_back(e0);
    if (n > 1) rdq.push_back(e1);
    host_u.frame(1'b1, a, n, 8'h00, lsb, fw);
  endtask : rd

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // watchers take the oldest note whenever a result shows up
  always @(rx_cnt) cmp("read_byte", rdq.pop_front(), rx_byte);
  always @(posedge sys_clk iff apl === 1'b1)
    #1 cmp("active", apq.pop_front(), act);

  initial begin
    #100us;
    num_errors++;
    results();
  end

  initial begin
    host_u.idle(8);
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    host_u.idle(4);
    foreach (ra[i]) rd(ra[i], re[i]);
    v = xs();
    wr(13'h230, v);
    rd(13'h230, v);
    cmp("active", 8'h00, act);
    wr(13'h004, 8'h01);
    rd(13'h230, 8'h00);
    apq.push_back(v);
    wr(13'h232, 8'h01);
    rd(13'h232, 8'h00);
    rd(13'h230, v);
    rd(13'h004, 8'h01, 2, VID);
    wr(13'h000, 8'h5a);
    lsb = 1'b1;
    rd(13'h003, VID, 2, 8'h01);
    wr(13'h000, 8'h18);
    lsb = 1'b0;
    wr(13'h000, 8'h99);
    fw = 1'b1;
    rd(13'h003, VID);
    rd(13'h000, 8'h99);
    // long-instruction bit must stay set
    wr(13'h000, 8'h18);
    fw = 1'b0;
    rd(13'h003, VID);
    wr(13'h000, 8'h3c);
    cmp("soft_reset", 8'h01, {7'h00, srst});
    cmp("active", 8'h00, act);
    rd(13'h000, 8'h3c);
    rd(13'h004, 8'h00);
    wr(13'h000, 8'h18);
    cmp("soft_reset", 8'h00, {7'h00, srst});
    // every noted read and apply must have shown up
    cmp("pending", 8'h00, 8'(rdq.size() + apq.size()));
    results();
  end
endmodule : tb_spc_top

`default_nettype wire
